// ### verif/step_dir_output_stage_bench.sv
// Bench for the step and direction output stage
`timescale 1ns/1ns
module step_dir_output_stage_bench;
    // One case: settings beside expected pin level and table direction
    typedef struct packed {
        logic [31:0] cfg;
        logic [31:0] tim;
        logic [23:0] vel;
        logic        dir;
        logic        fwd;
    } row_t;

    logic        clk;                  // System clock
    logic        reset_n;              // Active low reset
    logic [9:0]  address;              // Avalon byte address
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [31:0] readdata;
    logic        waitrequest;
    logic        step_output_pin;
    logic        direction_output_pin;
    logic [9:0]  microstep_counter;
    logic [31:0] cfg_m;                // Config as the driver model sees it
    logic [31:0] tim_m;                // Timing as the driver model sees it
    logic [31:0] rd;                   // Last word read
    int          steps;
    int          viol;
    int          width;
    int          fails;
    int          n_compared;
    int          s0;                   // Step count at row start
    row_t        rows [7];

    step_dir_output_stage step_dir_output_stage_i (
        .clk, .reset_n, .address, .read, .write, .writedata, .readdata,
        .waitrequest, .step_output_pin, .direction_output_pin,
        .microstep_counter
    );

    stepper_driver_model stepper_driver_model_i (
        .clk, .reset_n, .step_pin (step_output_pin),
        .dir_pin (direction_output_pin), .idle_level (cfg_m[3]),
        .toggle (cfg_m[4]), .extra (tim_m[15:0]), .setup (tim_m[31:16]),
        .steps, .viol, .width
    );

    // Free running clock
    always #25 clk = ~clk;

    // Wait a number of cycles
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Compare one value
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            fails++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Print counts and verdict, then stop
    task automatic end_sim;
        $display("compared %0d fails %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // One Avalon transfer; held until waitrequest is seen low
    task automatic bus(input logic w, input logic [9:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        address   <= a;
        write     <= w;
        read      <= !w;
        writedata <= d;
        do begin
            @(posedge clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 50);
        // One wait state, so the accept edge is the second one
        chk("wait cycles", 32'h2, 32'(n));
        if (n == 50)
            fails++;
        rd = readdata;
        if (w && a == 10'h000)
            cfg_m <= d;
        if (w && a == 10'h040)
            tim_m <= d;
        read  <= 1'b0;
        write <= 1'b0;
    endtask

    // Run one table row, stop, then check pins and position
    task automatic run_row(input row_t r);
        bus(1'b1, 10'h000, r.cfg);
        bus(1'b1, 10'h040, r.tim);
        bus(1'b1, 10'h104, 32'h100);
        s0 = steps;
        bus(1'b1, 10'h100, {8'h00, r.vel});
        bus(1'b0, 10'h088, 32'h0);
        chk("velocity", {{8{r.vel[23]}}, r.vel}, rd);
        cyc(400);
        bus(1'b1, 10'h100, 32'h0);
        cyc(100);
        chk("moved", 32'h1, 32'(steps > s0));
        chk("dir", {31'h0, r.dir}, {31'h0, direction_output_pin});
        // Counter was preloaded to 0x100 before the row moved
        chk("pos", 32'(10'(r.fwd ? 256 + steps - s0 : 256 + s0 - steps)),
            {22'h0, microstep_counter});
        chk("viol", 32'h0, viol);
        if (!r.cfg[4]) begin
            chk("width", 32'(r.tim[15:0]) + 32'h1, width);
            chk("idle", {31'h0, r.cfg[3]}, {31'h0, step_output_pin});
        end
        $display("row done, %0d steps", steps - s0);
    endtask

    // Watchdog well beyond the expected run
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        end_sim();
    end

    // Main sequence
    initial begin
        clk       = 1'b0;
        reset_n   = 1'b0;
        address   = 10'h000;
        read      = 1'b0;
        write     = 1'b0;
        writedata = 32'h0;
        cfg_m     = 32'h20;
        tim_m     = 32'h0;
        fails     = 0;
        n_compared = 0;
        // Toggle row last, so a stray level cannot look like a pulse
        rows = '{'{32'h20, 32'h0, 24'h0f4240, 1'b0, 1'b1},
                 '{32'h20, 32'h0004_0003, 24'hf0bdc0, 1'b1, 1'b0},
                 '{32'h00, 32'h0002_0001, 24'h0f4240, 1'b1, 1'b1},
                 '{32'h1000_0020, 32'h0001_0001, 24'h0f4240, 1'b1, 1'b0},
                 '{32'h1000_0000, 32'h0003_0003, 24'h7fffff, 1'b0, 1'b0},
                 '{32'h28, 32'h0001_0002, 24'hf0bdc0, 1'b1, 1'b0},
                 '{32'h30, 32'h0000_0001, 24'h0f4240, 1'b0, 1'b1}};
        cyc(20);
        reset_n <= 1'b1;
        foreach (rows[i])
            run_row(rows[i]);
        // Reset in mid motion leaves pins idle and global_config and timing back at their reset values
        bus(1'b1, 10'h100, 32'h7fffff);
        cyc(37);
        reset_n <= 1'b0;
        cfg_m   <= 32'h20;
        tim_m   <= 32'h0;
        cyc(20);
        chk("rst step", 32'h0, {31'h0, step_output_pin});
        chk("rst dir", 32'h0, {31'h0, direction_output_pin});
        reset_n <= 1'b1;
        bus(1'b0, 10'h000, 32'h0);
        chk("rst cfg", 32'h20, rd);
        bus(1'b0, 10'h040, 32'h0);
        chk("rst tim", 32'h0, rd);
        $display("reset test done");
        // Reversal at full rate with steps still queued
        bus(1'b1, 10'h040, 32'h0003_0002);
        bus(1'b1, 10'h100, 32'h7fffff);
        cyc(60);
        bus(1'b1, 10'h100, 32'h800001);
        cyc(200);
        chk("rev viol", 32'h0, viol);
        chk("rev dir", 32'h1, {31'h0, direction_output_pin});
        // Read-only velocity ignores writes; unmapped reads give zero
        bus(1'b1, 10'h088, 32'h123);
        bus(1'b0, 10'h088, 32'h0);
        chk("ro vel", 32'hff80_0001, rd);
        bus(1'b0, 10'h3fc, 32'h0);
        chk("unmapped", 32'h0, rd);
        $display("awkward tests done");
        end_sim();
    end
endmodule

// ### verif/stepper_driver_model.sv
// Stepper driver model: counts steps and flags timing faults
`timescale 1ns/1ns
module stepper_driver_model (
    // Clock, reset and driver pins
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        step_pin,
    input  wire logic        dir_pin,
    // Settings mirrored from the bench
    input  wire logic        idle_level,
    input  wire logic        toggle,
    input  wire logic [15:0] extra,
    input  wire logic [15:0] setup,
    // Results
    output int               steps,
    output int               viol,
    output int               width
);
    int   run_q;    // Cycles seen at active level
    int   dir_age;  // Cycles since direction change
    int   fall_age; // Cycles since pulse ended
    logic s_q;      // Last step level
    logic d_q;      // Last direction level
    logic idle_q;   // Last idle level, so a config flip is no step

    // Sample pins each edge; large start ages keep the first step legal
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            steps    <= 0;
            viol     <= 0;
            width    <= 0;
            run_q    <= 0;
            dir_age  <= 1000;
            fall_age <= 1000;
            s_q      <= step_pin;
            d_q      <= dir_pin;
            idle_q   <= idle_level;
        end else begin
            s_q      <= step_pin;
            d_q      <= dir_pin;
            idle_q   <= idle_level;
            dir_age  <= dir_age + 1;
            fall_age <= fall_age + 1;
            run_q    <= (step_pin != idle_level) ? run_q + 1 : 0;
            // Step edge: leaving the idle level, or any change when toggling
            if (step_pin != s_q && idle_level == idle_q &&
                (toggle || step_pin != idle_level)) begin
                steps <= steps + 1;
                if (dir_age + 1 < setup)
                    viol <= viol + 1;
            end
            // Pulse end: record its length
            if (!toggle && s_q != idle_q && step_pin == idle_level) begin
                width    <= run_q;
                fall_age <= 0;
            end
            // Direction may not move during a pulse or its hold time
            if (dir_pin != d_q) begin
                dir_age <= 0;
                if (!toggle && (s_q != idle_q || fall_age < extra))
                    viol <= viol + 1;
            end
        end
    end
endmodule

// ### verilog/avalon_reg_slave.sv
// Avalon-MM register slave front end with one wait state
`timescale 1ns/1ns
module avalon_reg_slave (
    // Clock and reset
    input  wire logic                    clk,
    input  wire logic                    reset_n,
    // Avalon-MM slave
    input  wire logic [9:0]              address,
    input  wire logic                    read,
    input  wire logic                    write,
    input  wire logic [31:0]             writedata,
    output logic                         waitrequest,
    // Decoded access, one cycle long
    output step_dir_pkg::bus_acc_t       acc
);
    logic busy_q, busy_d;   // Wait state flag

    // Hold waitrequest for one cycle, then release on the access cycle
    always_comb begin
        busy_d = (read || write) && !busy_q;
    end

    // Register stage
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            busy_q <= 1'b0;
        end else begin
            busy_q <= busy_d;
        end
    end

    // Accept in the second cycle of any request
    assign waitrequest = (read || write) && !busy_q;
    assign acc.wr      = write && busy_q;
    assign acc.rd      = read && busy_q;
    assign acc.idx     = address[9:2];
    assign acc.wdata   = writedata;
endmodule

// ### verilog/step_dir_output_stage.sv
// Step and direction output stage with its register file
//
// Register access over Avalon-MM was left to the implementer.
`timescale 1ns/1ns
// Function
// RQ1: Step active for extra plus one cycles
// RQ2: No step for setup cycles after direction change
// RQ3: Direction frozen while step is active
// RQ4: Direction frozen extra plus one after pulse
// RQ5: Step output active high by default
// RQ6: Idle level bit inverts step output
// RQ7: Toggle mode: every edge is a step
// RQ8: Polarity bit set means high is negative
// RQ9: Direction follows microstep counter movement
// RQ10: Positive velocity steps forward through table
// RQ11: Invert bit reverses table direction
// RQ12: Velocity readable as signed 24 bit
// RQ13: One pulse per microstep, pending steps queued
// RQ14: Reset leaves outputs idle and forward
module step_dir_output_stage (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        reset_n,
    // Avalon-MM slave, byte address
    input  wire logic [9:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    output logic [31:0]      readdata,
    output logic             waitrequest,
    // Driver pins
    output logic             step_output_pin,
    output logic             direction_output_pin,
    // Observed state
    output logic [9:0]       microstep_counter
);
    // Stage sequence: idle, pulse, hold after pulse, direction setup
    typedef enum logic [1:0] {st_idle, st_pulse, st_hold, st_setup} st_t;

    step_dir_pkg::bus_acc_t  acc;        // Decoded bus access
    step_dir_pkg::step_req_t req;        // Step waiting for the stage
    step_dir_pkg::timing_t   tim;        // Timing fields
    step_dir_pkg::out_cfg_t  cfg;        // Output configuration
    logic [31:0] gconf_q, gconf_d;       // global_config
    logic [31:0] timing_q, timing_d;     // step_direction_timing
    logic [23:0] vel_q, vel_d;           // present_velocity
    logic [31:0] rdata_q, rdata_d;       // Read data latch
    st_t         st_q, st_d;             // Stage state
    logic [16:0] cnt_q, cnt_d;           // Phase counter, up to 2^16 - 1
    logic        dir_q, dir_d;           // Logical direction, 1 = backward
    logic        lvl_q, lvl_d;           // Raw step level before polarity
    logic        take;                   // Stage accepts the pending step
    logic        pos_load;               // Software preload of the counter

    // Register bus front end
    avalon_reg_slave u_bus (
        .clk         (clk),
        .reset_n     (reset_n),
        .address     (address),
        .read        (read),
        .write       (write),
        .writedata   (writedata),
        .waitrequest (waitrequest),
        .acc         (acc)
    );

    assign tim = step_dir_pkg::timing_t'(timing_q);
    // Members in struct order: idle level, toggle, polarity, invert
    assign cfg = {gconf_q[step_dir_pkg::step_idle_level_bit],
                  gconf_q[step_dir_pkg::step_on_each_edge_bit],
                  gconf_q[step_dir_pkg::dir_polarity_bit],
                  gconf_q[step_dir_pkg::invert_motion_bit]};
    assign pos_load = acc.wr && acc.idx == step_dir_pkg::idx_microstep_pos;

    // Velocity to step requests and microstep counter
    step_rate_gen u_rate (
        .clk               (clk),
        .reset_n           (reset_n),
        .velocity          (vel_q),
        .invert_motion     (cfg.invert_motion),
        .req               (req),
        .req_taken         (take),
        .pos_load          (pos_load),
        .pos_value         (acc.wdata[9:0]),
        .microstep_counter (microstep_counter)
    );

    // Register writes and read mux
    always_comb begin
        gconf_d  = gconf_q;
        timing_d = timing_q;
        vel_d    = vel_q;
        rdata_d  = rdata_q;
        if (acc.wr) begin
            case (acc.idx)
                step_dir_pkg::idx_global_config:   gconf_d  = acc.wdata;
                step_dir_pkg::idx_step_dir_timing: timing_d = acc.wdata;
                step_dir_pkg::idx_velocity_cmd:    vel_d    = acc.wdata[23:0];
                default: ;
            endcase
        end
        // Read word captured while waitrequest is still high
        if (read && waitrequest) begin
            case (acc.idx)
                step_dir_pkg::idx_global_config:   rdata_d = gconf_q;
                step_dir_pkg::idx_step_dir_timing: rdata_d = timing_q;
                // Signed velocity, sign extended into the upper byte [RQ12]
                step_dir_pkg::idx_present_vel:
                    rdata_d = {{8{vel_q[23]}}, vel_q};
                step_dir_pkg::idx_velocity_cmd:
                    rdata_d = {{8{vel_q[23]}}, vel_q};
                step_dir_pkg::idx_microstep_pos:
                    rdata_d = {22'h00_0000, microstep_counter};
                default: rdata_d = 32'h0000_0000;
            endcase
        end
    end

    // Register file storage
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            gconf_q  <= step_dir_pkg::global_config_rst;
            timing_q <= step_dir_pkg::timing_rst;
            vel_q    <= step_dir_pkg::velocity_rst;
            rdata_q  <= 32'h0000_0000;
        end else begin
            gconf_q  <= gconf_d;
            timing_q <= timing_d;
            vel_q    <= vel_d;
            rdata_q  <= rdata_d;
        end
    end

    // Read word latched in the wait cycle, so readdata comes from a flop
    // and stands through the accept cycle; it is one cycle old by then
    assign readdata = rdata_q;

    // Stage sequencer
    always_comb begin
        st_d  = st_q;
        cnt_d = cnt_q;
        dir_d = dir_q;
        lvl_d = lvl_q;
        take  = 1'b0;
        // Leaving toggle mode must not strand the step at its active
        // level, or the next pulse would show no edge at all
        if (!cfg.step_on_each_edge && st_q != st_pulse) begin
            lvl_d = 1'b0; // [RQ5]
        end
        case (st_q)
            st_idle: begin
                if (req.valid) begin
                    if (req.backward != dir_q) begin
                        // Direction moves only with no pulse [RQ3] [RQ9]
                        dir_d = req.backward;
                        st_d  = st_setup;
                        cnt_d = {1'b0, tim.dir_setup};
                    end else begin
                        // Queued step is issued now [RQ13]
                        take  = 1'b1;
                        lvl_d = cfg.step_on_each_edge ? !lvl_q : 1'b1; // [RQ7]
                        st_d  = st_pulse;
                        cnt_d = {1'b0, tim.pulse_extra}; // [RQ1]
                    end
                end
            end
            st_setup: begin
                // Steps held back for the setup time [RQ2]
                if (cnt_q == 17'h0_0000 || cnt_q == 17'h0_0001) begin
                    st_d  = st_idle;
                    cnt_d = 17'h0_0000;
                end else begin
                    cnt_d = cnt_q - 17'h0_0001;
                end
            end
            st_pulse: begin
                if (cnt_q == 17'h0_0000) begin
                    if (!cfg.step_on_each_edge) begin
                        lvl_d = 1'b0;
                    end
                    st_d  = st_hold;
                    cnt_d = {1'b0, tim.pulse_extra};
                end else begin
                    cnt_d = cnt_q - 17'h0_0001;
                end
            end
            st_hold: begin
                // Direction kept after pulse end [RQ4]
                if (cnt_q == 17'h0_0000) begin
                    st_d = st_idle;
                end else begin
                    cnt_d = cnt_q - 17'h0_0001;
                end
            end
            default: st_d = st_idle;
        endcase
    end

    // Stage registers; reset puts the step idle and direction forward
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_q  <= st_idle;
            cnt_q <= 17'h0_0000;
            dir_q <= 1'b0;   // [RQ14]
            lvl_q <= 1'b0;   // [RQ14]
        end else begin
            st_q  <= st_d;
            cnt_q <= cnt_d;
            dir_q <= dir_d;
            lvl_q <= lvl_d;
        end
    end

    // Pin levels: active high step unless idle bit set [RQ5] [RQ6]
    assign step_output_pin      = lvl_q ^ cfg.step_idle_level;
    // Polarity set: high means backward (negative) [RQ8]
    assign direction_output_pin = cfg.dir_polarity ? dir_q : !dir_q;

    // Checks
    property p_pulse_len;
        @(posedge clk) disable iff (!reset_n)
        (st_q == st_idle && st_d == st_pulse && tim.pulse_extra == 16'h0000)
        |=> st_q == st_pulse ##1 st_q == st_hold;
    endproperty
    a_pulse_len: assert property (p_pulse_len) // [RQ1]
        else $error("step pulse length wrong");
    property p_no_dir_in_pulse;
        @(posedge clk) disable iff (!reset_n)
        (st_q == st_pulse || st_q == st_hold) |=> $stable(dir_q);
    endproperty
    a_no_dir_in_pulse: assert property (p_no_dir_in_pulse) // [RQ3]
        else $error("direction moved during pulse");
    property p_hold_after;
        @(posedge clk) disable iff (!reset_n)
        (st_q == st_pulse && st_d == st_hold) |=> st_q == st_hold;
    endproperty
    a_hold_after: assert property (p_hold_after) // [RQ4]
        else $error("hold phase skipped");
    property p_setup;
        @(posedge clk) disable iff (!reset_n)
        $changed(dir_q) |-> st_q == st_setup && !take;
    endproperty
    a_setup: assert property (p_setup) // [RQ2]
        else $error("step right after direction change");
    property p_idle_level;
        @(posedge clk) disable iff (!reset_n)
        (st_q == st_idle && !cfg.step_on_each_edge &&
         !$past(cfg.step_on_each_edge))
        |-> step_output_pin == cfg.step_idle_level;
    endproperty
    a_idle_level: assert property (p_idle_level) // [RQ6]
        else $error("step idle level wrong");
    property p_toggle;
        @(posedge clk) disable iff (!reset_n)
        (take && cfg.step_on_each_edge) |=> $changed(lvl_q);
    endproperty
    a_toggle: assert property (p_toggle) // [RQ7]
        else $error("toggle step missing");
    property p_dir_pol;
        @(posedge clk) disable iff (!reset_n)
        direction_output_pin == (dir_q ~^ cfg.dir_polarity);
    endproperty
    a_dir_pol: assert property (p_dir_pol) // [RQ8]
        else $error("direction polarity wrong");
    property p_count;
        @(posedge clk) disable iff (!reset_n)
        (take && !pos_load) |=> microstep_counter != $past(microstep_counter);
    endproperty
    a_count: assert property (p_count) // [RQ13]
        else $error("step without counter move");
    c_pulse: cover property (@(posedge clk) st_q == st_pulse);
    c_setup: cover property (@(posedge clk) st_q == st_setup);
    property p_step_edge;
        @(posedge clk) disable iff (!reset_n)
        (take && !cfg.step_on_each_edge && !cfg.step_idle_level &&
         !acc.wr && !step_output_pin) |=> $rose(step_output_pin);
    endproperty
    a_step_edge: assert property (p_step_edge) // [RQ5]
        else $error("step without rising edge");
    property p_read_data;
        @(posedge clk) disable iff (!reset_n)
        (read && waitrequest) |=> acc.rd && readdata == $past(rdata_d);
    endproperty
    a_read_data: assert property (p_read_data) // [RQ12]
        else $error("read data not standing on accept");
    c_toggle: cover property (@(posedge clk) take && cfg.step_on_each_edge);
    c_inverted: cover property (@(posedge clk) take && cfg.step_idle_level);
    c_read: cover property (@(posedge clk) acc.rd);
endmodule

// ### verilog/step_dir_pkg.sv
// Shared constants and carrier types for the step/direction output stage
package step_dir_pkg;
    // Register indices as printed; byte address is four times the index
    localparam logic [7:0] idx_global_config   = 8'h00;
    localparam logic [7:0] idx_step_dir_timing = 8'h10;
    localparam logic [7:0] idx_present_vel     = 8'h22;
    localparam logic [7:0] idx_velocity_cmd    = 8'h40;
    localparam logic [7:0] idx_microstep_pos   = 8'h41;

    // Field positions in global_config
    localparam int step_idle_level_bit   = 3;
    localparam int step_on_each_edge_bit = 4;
    localparam int dir_polarity_bit      = 5;
    localparam int invert_motion_bit     = 28;

    // Reset values
    localparam logic [31:0] global_config_rst = 32'h0000_0020;
    localparam logic [31:0] timing_rst        = 32'h0000_0000;
    localparam logic [23:0] velocity_rst      = 24'h00_0000;
    localparam logic [9:0]  microstep_rst     = 10'h000;

    // Rate of the step rate accumulator in clock cycles per velocity unit
    localparam int          clk_rate_hz       = 20_000_000;
    localparam logic [24:0] accum_modulus     = 25'(clk_rate_hz);

    // Timing fields taken from the timing register
    typedef struct packed {
        logic [15:0] dir_setup;
        logic [15:0] pulse_extra;
    } timing_t;

    // Configuration bits steering the output stage
    typedef struct packed {
        logic step_idle_level;
        logic step_on_each_edge;
        logic dir_polarity;
        logic invert_motion;
    } out_cfg_t;

    // Request from the motion side into the pulse stage
    typedef struct packed {
        logic valid;
        logic backward;
    } step_req_t;

    // Bus access decoded by the register slave
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  idx;
        logic [31:0] wdata;
    } bus_acc_t;
endpackage

// ### verilog/step_rate_gen.sv
// Velocity to step request generator with a wrapping microstep position
`timescale 1ns/1ns
module step_rate_gen (
    // Clock and reset
    input  wire logic                    clk,
    input  wire logic                    reset_n,
    // Velocity and configuration
    input  wire logic [23:0]             velocity,
    input  wire logic                    invert_motion,
    // Handshake with the pulse stage
    output step_dir_pkg::step_req_t      req,
    input  wire logic                    req_taken,
    // Microstep counter preload and state
    input  wire logic                    pos_load,
    input  wire logic [9:0]              pos_value,
    output logic [9:0]                   microstep_counter
);
    logic [24:0] accum_q, accum_d;   // Phase accumulator
    logic        pend_q, pend_d;      // One step waiting for the stage
    logic        back_q, back_d;      // Its direction through the table
    logic [9:0]  microstep_counter_q, microstep_counter_d;    // Microstep position
    logic [23:0] speed;               // Magnitude of velocity
    logic [25:0] sum;

    // Next values; a step is only counted when the stage takes it
    always_comb begin
        speed   = velocity[23] ? 24'(-velocity) : velocity;
        sum     = {1'b0, accum_q} + {2'b00, speed};
        accum_d = accum_q;
        pend_d  = pend_q;
        back_d  = back_q;
        microstep_counter_d = microstep_counter_q;
        if (pend_q && req_taken) begin
            pend_d  = 1'b0;
            // Counter moves one unit per step [RQ13]
            microstep_counter_d = back_q ? microstep_counter_q - 10'h001 : microstep_counter_q + 10'h001;
        end
        // Accumulator stalls while a step still waits, so none is lost
        if (!pend_d && speed != 24'h00_0000) begin
            if (sum >= {1'b0, step_dir_pkg::accum_modulus}) begin
                accum_d = 25'(sum - {1'b0, step_dir_pkg::accum_modulus});
                pend_d  = 1'b1;
                // Sign of velocity picks the table direction [RQ10] [RQ11]
                back_d  = velocity[23] ^ invert_motion;
            end else begin
                accum_d = sum[24:0];
            end
        end
        if (pos_load) begin
            microstep_counter_d = pos_value;
        end
    end

    // Register stage
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            accum_q <= 25'h000_0000;
            pend_q  <= 1'b0;
            back_q  <= 1'b0;
            microstep_counter_q <= step_dir_pkg::microstep_rst;
        end else begin
            accum_q <= accum_d;
            pend_q  <= pend_d;
            back_q  <= back_d;
            microstep_counter_q <= microstep_counter_d;
        end
    end

    assign req.valid         = pend_q;
    assign req.backward      = back_q;
    assign microstep_counter = microstep_counter_q;
endmodule
